// ==== flash_ctrl_pkg.sv ====
// Shared constants and types for the embedded flash controller and its host end
package flash_ctrl_pkg;
   // Key words, the same pair serves the control lock and the option lock
   localparam logic [31:0] FIRST_UNLOCK_KEY = 32'h45670123;
   localparam logic [31:0] SECOND_UNLOCK_KEY = 32'hcdef89ab;
   // Erased half-word and erased option byte
   localparam logic [15:0] ERASED_HALF = 16'hffff;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // Read protection codes
   localparam logic [7:0] PROT_LEVEL0_CODE = 8'haa;
   localparam logic [7:0] PROT_LEVEL2_CODE = 8'hcc;
   // Protection level encoding
   localparam logic [1:0] LEVEL0 = 2'h0;
   localparam logic [1:0] LEVEL1 = 2'h1;
   localparam logic [1:0] LEVEL2 = 2'h2;
   // Array geometry: pages of half-words, write protection per group of pages
   localparam int PAGE_BITS = 6;
   localparam int WORD_BITS = 4;
   localparam int ADDR_BITS = PAGE_BITS + WORD_BITS;
   localparam int PAGES_PER_GROUP_LOG = 2;
   localparam int GROUP_COUNT = 32;
   // Option byte slots in the stored image: byte k at index 2k, complement at 2k+1
   localparam int OPT_BYTES = 8;
   localparam logic [2:0] OPT_RDP = 3'h0;
   localparam logic [2:0] OPT_WRP0 = 3'h4;
   localparam logic [7:0] OPT_RDP_RESET = 8'ha5;
   // Operation codes carried on the link
   typedef enum logic [2:0] {
      OP_NONE, OP_KEY, OP_OPTKEY, OP_CTRL, OP_PROG, OP_PAGE_ERASE, OP_MASS_ERASE, OP_OPT_PROG
   } op_e;
   // Control word bits written with OP_CTRL
   localparam int CTRL_LOCK = 0;
   localparam int CTRL_OPT_WEN_CLR = 1;
   localparam int CTRL_OPT_ERASE = 2;
   localparam int CTRL_IRQ_EN = 3;
   localparam int CTRL_PREFETCH = 4;
   localparam int CTRL_HALF_CYCLE = 5;
   localparam int CTRL_WAIT = 6;
   localparam int CTRL_STATUS_CLR = 7;
   // Host register map (word offsets of its own port)
   localparam logic [3:0] HREG_CMD = 4'h0;
   localparam logic [3:0] HREG_ADDR = 4'h1;
   localparam logic [3:0] HREG_DATA = 4'h2;
   localparam logic [3:0] HREG_STATUS = 4'h3;
   localparam logic [3:0] HREG_READ = 4'h4;
   localparam logic [3:0] HREG_MODE = 4'h5;
   // Status word positions
   localparam int ST_DONE = 0;
   localparam int ST_PROG_ERR = 1;
   localparam int ST_WP_ERR = 2;
   localparam int ST_OPT_ERR = 3;
   localparam int ST_LOCKED = 4;
   localparam int ST_DEAD = 5;
   localparam int ST_OPT_WEN = 6;
   localparam int ST_IRQ = 7;
   // Host clock limits for the read configuration
   localparam int CLOCK_MHZ = 50;
   localparam int ZERO_WAIT_MAX_MHZ = 24;
   localparam int PREFETCH_MAX_MHZ = 24;
   localparam int HALF_CYCLE_MAX_MHZ = 8;
endpackage

// ==== flash_link_if.sv ====
// Link between the core-side host end and the flash controller
`timescale 1ns/100ps
interface flash_link_if;
   logic req;
   logic [2:0] op;
   logic [31:0] wdata;
   logic [9:0] addr;
   logic rdReq;
   logic ack;
   logic [15:0] rdata;
   logic [7:0] status;
   logic [7:0] ctrlState;
   modport host (output req, op, wdata, addr, rdReq, input ack, rdata, status, ctrlState);
   modport ctrl (input req, op, wdata, addr, rdReq, output ack, rdata, status, ctrlState);
endinterface

// ==== flash_ctrl.sv ====
// Flash controller end: locks, protection, erase and program of a half-word array
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
// Function
// (R01) Host picks wait states by clock rate
// (R02) Prefetch on at reset, changed under limits
// (R03) Half-cycle access only at low clock
// (R04) Erase sets half-words to all ones
// (R05) Program over non-erased cell flags error
// (R06) Page erase touches one page only
// (R07) Main-array success sets completion flag
// (R08) Host gives valid, unprotected erase page
// (R09) Mass erase clears whole array
// (R10) Programming takes half-words only
// (R11) Program to protected page flags error
// (R12) One protect bit per four pages
// (R13) Protection byte decodes to three levels
// (R14) Level one blocks debug array access
// (R15) Level two refuses debug and changes
// (R16) Protected pages reject erase and program
// (R17) Two-key sequence unlocks control
// (R18) Bad key locks until reset
// (R19) Lock bit relocks controller
// (R20) Option success sets completion flag
// (R21) Option key sets option write enable
// (R22) Option changes apply after reset
// (R23) Reload checks complements, errors force ones
// (R24) Protect bit zero means protected
module flash_ctrl #(
   parameter int ADDR_W = flash_ctrl_pkg::ADDR_BITS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Link to the host end
   flash_link_if.ctrl link,
   // Execution context from the core
   input wire logic debugMode,
   // Configuration seen by the read path, and the interrupt
   output logic prefetchOn,
   output logic halfCycleOn,
   output logic waitState,
   output logic irq
);
   localparam int WORDS = 1 << ADDR_W;
   localparam int OPT_SLOTS = 2 * flash_ctrl_pkg::OPT_BYTES;

   // Array and non-volatile option image; these keep their content across reset
   logic [15:0] mem [WORDS];
   logic [7:0] optStore [OPT_SLOTS];
   logic [7:0] optLive [flash_ctrl_pkg::OPT_BYTES];

   typedef enum {S_LOAD, S_IDLE} state_e;
   state_e state;
   logic [3:0] loadIdx;
   logic keyHalf, unlocked, dead, optKeyHalf, optWen;
   logic done, progErr, wpErr, optErr, irqEn;
   logic ack;
   logic [15:0] rdata;

   // Decode of the protection level byte
   function automatic logic [1:0] level_of(input logic [7:0] b);
      if (b == flash_ctrl_pkg::PROT_LEVEL0_CODE) level_of = flash_ctrl_pkg::LEVEL0; // R13
      else if (b == flash_ctrl_pkg::PROT_LEVEL2_CODE) level_of = flash_ctrl_pkg::LEVEL2;
      else level_of = flash_ctrl_pkg::LEVEL1;
   endfunction

   // Request decode
   wire logic go = link.req && state == S_IDLE;
   wire logic [2:0] op = link.op;
   wire logic [1:0] level = level_of(optLive[flash_ctrl_pkg::OPT_RDP]);
   wire logic [ADDR_W-1:0] addr = link.addr[ADDR_W-1:0];
   wire logic [flash_ctrl_pkg::PAGE_BITS-1:0] page = addr[ADDR_W-1 -: flash_ctrl_pkg::PAGE_BITS];
   wire logic [4:0] group = 5'(page >> flash_ctrl_pkg::PAGES_PER_GROUP_LOG); // R12
   wire logic [31:0] wrpBits = {optLive[7], optLive[6], optLive[5], optLive[4]};
   wire logic protPage = !wrpBits[group]; // R24
   wire logic arrayBlocked = (level == flash_ctrl_pkg::LEVEL1 && debugMode)
                             || level == flash_ctrl_pkg::LEVEL2; // R14 R15
   wire logic mainOk = unlocked && !dead && !arrayBlocked;
   wire logic optOk = mainOk && optWen && level != flash_ctrl_pkg::LEVEL2; // R15 R21
   wire logic keyMatch1 = link.wdata == flash_ctrl_pkg::FIRST_UNLOCK_KEY;
   wire logic keyMatch2 = link.wdata == flash_ctrl_pkg::SECOND_UNLOCK_KEY;
   wire logic [2:0] optSel = link.addr[2:0];
   wire logic [1:0] newLevel = level_of(link.wdata[7:0]);
   wire logic prefetchWin = link.wdata[flash_ctrl_pkg::CTRL_PREFETCH];

   // Option reload after reset, then request service
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_LOAD;
         loadIdx <= '0;
         optErr <= 1'b0;
      end else if (state == S_LOAD) begin
         if (optStore[2*loadIdx] == flash_ctrl_pkg::ERASED_BYTE
             && optStore[2*loadIdx+1] == flash_ctrl_pkg::ERASED_BYTE) begin
            optLive[loadIdx[2:0]] <= flash_ctrl_pkg::ERASED_BYTE; // R23
         end else if (optStore[2*loadIdx] != ~optStore[2*loadIdx+1]) begin
            optLive[loadIdx[2:0]] <= flash_ctrl_pkg::ERASED_BYTE; // R23
            optErr <= 1'b1;
         end else begin
            optLive[loadIdx[2:0]] <= optStore[2*loadIdx];
         end
         loadIdx <= loadIdx + 4'h1;
         if (loadIdx == 4'(flash_ctrl_pkg::OPT_BYTES - 1)) state <= S_IDLE;
      end
   end

   // Keys, lock and option write enable
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         keyHalf <= 1'b0;
         unlocked <= 1'b0; // R17
         dead <= 1'b0;
         optKeyHalf <= 1'b0;
         optWen <= 1'b0; // R21
      end else if (go) begin
         if (op == flash_ctrl_pkg::OP_KEY && !dead) begin
            if (!keyHalf && keyMatch1) keyHalf <= 1'b1; // R17
            else if (keyHalf && keyMatch2 && !unlocked) unlocked <= 1'b1;
            else dead <= 1'b1; // R18
            if (keyHalf) keyHalf <= 1'b0;
         end
         if (op == flash_ctrl_pkg::OP_OPTKEY && unlocked && !dead) begin
            if (!optKeyHalf && keyMatch1) optKeyHalf <= 1'b1;
            else if (optKeyHalf && keyMatch2) optWen <= 1'b1; // R21
            else dead <= 1'b1;
            if (optKeyHalf) optKeyHalf <= 1'b0;
         end
         if (op == flash_ctrl_pkg::OP_CTRL && mainOk) begin
            if (link.wdata[flash_ctrl_pkg::CTRL_LOCK]) unlocked <= 1'b0; // R19
            if (link.wdata[flash_ctrl_pkg::CTRL_OPT_WEN_CLR]) optWen <= 1'b0; // R21
         end
      end
   end

   // Array and option image modification; no reset so content survives
   always_ff @(posedge clock) begin
      if (go && mainOk) begin
         if (op == flash_ctrl_pkg::OP_PROG && !protPage
             && mem[addr] == flash_ctrl_pkg::ERASED_HALF)
            mem[addr] <= link.wdata[15:0]; // R10
         if (op == flash_ctrl_pkg::OP_PAGE_ERASE && !protPage)
            for (int w = 0; w < (1 << flash_ctrl_pkg::WORD_BITS); w++)
               mem[{page, 4'(w)}] <= flash_ctrl_pkg::ERASED_HALF; // R04 R06 R16
      end
      if (go && mainOk && op == flash_ctrl_pkg::OP_MASS_ERASE
          || go && optOk && op == flash_ctrl_pkg::OP_OPT_PROG
             && level == flash_ctrl_pkg::LEVEL1 && newLevel == flash_ctrl_pkg::LEVEL0
             && optSel == flash_ctrl_pkg::OPT_RDP)
         for (int w = 0; w < WORDS; w++) mem[w] <= flash_ctrl_pkg::ERASED_HALF; // R09 R14
      if (go && optOk && op == flash_ctrl_pkg::OP_OPT_PROG) begin
         optStore[2*optSel] <= link.wdata[7:0]; // R22
         optStore[2*optSel+1] <= ~link.wdata[7:0];
      end
      if (go && optOk && op == flash_ctrl_pkg::OP_CTRL
          && link.wdata[flash_ctrl_pkg::CTRL_OPT_ERASE])
         for (int s = 0; s < OPT_SLOTS; s++) optStore[s] <= flash_ctrl_pkg::ERASED_BYTE;
   end

   // Status flags, read configuration, answers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         done <= 1'b0;
         progErr <= 1'b0;
         wpErr <= 1'b0;
         irqEn <= 1'b0;
         prefetchOn <= 1'b1; // R02
         halfCycleOn <= 1'b0;
         waitState <= 1'b0;
         irq <= 1'b0;
         ack <= 1'b0;
         rdata <= '0;
      end else begin
         ack <= go || (link.rdReq && state == S_IDLE);
         irq <= irqEn && done; // R07 R20
         if (go && op == flash_ctrl_pkg::OP_CTRL && mainOk) begin
            if (link.wdata[flash_ctrl_pkg::CTRL_STATUS_CLR]) begin
               done <= 1'b0;
               progErr <= 1'b0;
               wpErr <= 1'b0;
            end
            irqEn <= link.wdata[flash_ctrl_pkg::CTRL_IRQ_EN];
            // Prefetch only moves while the host reports a low, equal clock
            if (link.wdata[flash_ctrl_pkg::CTRL_WAIT] == 1'b0) prefetchOn <= prefetchWin; // R02
            halfCycleOn <= link.wdata[flash_ctrl_pkg::CTRL_HALF_CYCLE];
            waitState <= link.wdata[flash_ctrl_pkg::CTRL_WAIT];
         end
         // Set after clear so a completion in the same cycle is kept
         if (go && mainOk && (op == flash_ctrl_pkg::OP_PROG || op == flash_ctrl_pkg::OP_PAGE_ERASE))
         begin
            if (protPage) wpErr <= 1'b1; // R11 R16
            else if (op == flash_ctrl_pkg::OP_PROG && mem[addr] != flash_ctrl_pkg::ERASED_HALF)
               progErr <= 1'b1; // R05
            else done <= 1'b1; // R07
         end
         if (go && mainOk && op == flash_ctrl_pkg::OP_MASS_ERASE) done <= 1'b1;
         if (go && optOk && (op == flash_ctrl_pkg::OP_OPT_PROG || op == flash_ctrl_pkg::OP_CTRL
             && link.wdata[flash_ctrl_pkg::CTRL_OPT_ERASE])) done <= 1'b1; // R20
         if (link.rdReq && state == S_IDLE)
            rdata <= arrayBlocked ? '0 : mem[link.addr[ADDR_W-1:0]]; // R14 R15
      end
   end

   assign link.ack = ack;
   assign link.rdata = rdata;
   assign link.status = {irq, optWen, dead, !unlocked, optErr, wpErr, progErr, done};
   assign link.ctrlState = {4'h0, waitState, halfCycleOn, prefetchOn, state == S_LOAD};
endmodule

// ==== flash_host.sv ====
// Host end: register port for software, drives requests into the flash controller
`timescale 1ns/100ps
module flash_host (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Software register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   // Link to the controller
   flash_link_if.host link
);
   logic [9:0] addrReg;
   logic [31:0] dataReg;
   logic req, rdReq, rdWait;
   logic [2:0] opReg;
   logic [15:0] readBack;

   // Host clock limits guide the control word it forwards
   localparam logic ZERO_WAIT_OK = flash_ctrl_pkg::CLOCK_MHZ <= flash_ctrl_pkg::ZERO_WAIT_MAX_MHZ;
   localparam logic HALF_OK = flash_ctrl_pkg::CLOCK_MHZ <= flash_ctrl_pkg::HALF_CYCLE_MAX_MHZ;

   wire logic cmdWrite = regWrite && regAddr == flash_ctrl_pkg::HREG_CMD;
   wire logic isCtrl = regWdata[2:0] == 3'(flash_ctrl_pkg::OP_CTRL);
   // Force wait state above the zero-wait limit, refuse half-cycle above its limit
   wire logic [31:0] ctrlWord = {dataReg[31:7], !ZERO_WAIT_OK || dataReg[6], // R01
                                 dataReg[5] && HALF_OK, dataReg[4:0]}; // R03

   // Register writes and request issue
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         addrReg <= '0;
         dataReg <= '0;
         req <= 1'b0;
         rdReq <= 1'b0;
         opReg <= '0;
      end else begin
         req <= cmdWrite && regWdata[2:0] != 3'(flash_ctrl_pkg::OP_NONE);
         rdReq <= regWrite && regAddr == flash_ctrl_pkg::HREG_READ;
         if (cmdWrite) opReg <= regWdata[2:0];
         if (regWrite && regAddr == flash_ctrl_pkg::HREG_ADDR) addrReg <= regWdata[9:0];
         if (regWrite && regAddr == flash_ctrl_pkg::HREG_READ) addrReg <= regWdata[9:0];
         if (regWrite && regAddr == flash_ctrl_pkg::HREG_DATA) dataReg <= regWdata;
         if (cmdWrite && isCtrl) dataReg <= ctrlWord; // R01 R03
      end
   end

   // Read data of the software port, one cycle after the strobe
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         regRdata <= '0;
         readBack <= '0;
         rdWait <= 1'b0;
      end else begin
         // The answer comes one cycle after the pulse, so the pulse is remembered
         rdWait <= rdReq;
         if (link.ack && rdWait) readBack <= link.rdata;
         regRdata <= '0;
         if (regRead) begin
            case (regAddr)
               flash_ctrl_pkg::HREG_ADDR: regRdata <= {22'h0, addrReg};
               flash_ctrl_pkg::HREG_DATA: regRdata <= dataReg;
               flash_ctrl_pkg::HREG_STATUS: regRdata <= {24'h0, link.status};
               flash_ctrl_pkg::HREG_READ: regRdata <= {16'h0, readBack};
               flash_ctrl_pkg::HREG_MODE: regRdata <= {24'h0, link.ctrlState};
               default: regRdata <= '0;
            endcase
         end
      end
   end

   assign link.req = req;
   assign link.op = opReg;
   assign link.wdata = dataReg;
   assign link.addr = addrReg;
   assign link.rdReq = rdReq;
endmodule

// ==== flash_ctrl_asserts.sv ====
// Concurrent checks on the link between the host end and the flash controller
`timescale 1ns/100ps
module flash_ctrl_asserts (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Requests from the host end
   input wire logic req,
   input wire logic [2:0] op,
   input wire logic [31:0] wdata,
   input wire logic [9:0] addr,
   input wire logic rdReq,
   // Answers from the controller
   input wire logic ack,
   input wire logic [15:0] rdata,
   input wire logic [7:0] status,
   input wire logic [7:0] ctrlState
);
   // One clock domain, so every check shares the clock and sleeps through reset
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   // Decodes shared by several checks
   wire locked = status[flash_ctrl_pkg::ST_LOCKED];
   wire dead = status[flash_ctrl_pkg::ST_DEAD];
   wire ctrlReq = req && (op == flash_ctrl_pkg::OP_CTRL);
   wire keyReq = req && (op == flash_ctrl_pkg::OP_KEY);
   wire badKey = (wdata != flash_ctrl_pkg::FIRST_UNLOCK_KEY)
      && (wdata != flash_ctrl_pkg::SECOND_UNLOCK_KEY);

   prog_ack_a: assert property (req && op == flash_ctrl_pkg::OP_PROG |=> ack)
      else $error("program request not acknowledged");
   read_ack_a: assert property (rdReq |=> ack)
      else $error("read request not acknowledged");
   // Interrupt is registered from the completion flag, so it trails it by one cycle
   irq_done_a: assert property (status[flash_ctrl_pkg::ST_IRQ]
      |-> $past(status[flash_ctrl_pkg::ST_DONE]))
      else $error("interrupt without completion flag");
   bad_key_a: assert property (keyReq && locked && badKey |=> dead)
      else $error("wrong key did not kill the controller");
   dead_frozen_a: assert property (dead |=> $stable(status))
      else $error("status changed after a wrong key");
   relock_a: assert property (ctrlReq && wdata[0] && !dead |=> locked)
      else $error("lock bit did not relock");
   wait_set_a: assert property (ctrlReq && !locked && !dead |=> ctrlState[3])
      else $error("wait state not set at this clock rate");
   locked_ctrl_a: assert property (ctrlReq && locked |=> $stable(ctrlState[3:1]))
      else $error("control changed while locked");
   half_off_a: assert property (!ctrlState[2])
      else $error("half-cycle access on at this clock rate");
   prefetch_rst_a: assert property ($rose(arst_n) |-> ctrlState[1])
      else $error("prefetch not on after reset");

   // Main scenarios reached
   cover property (keyReq && locked && badKey);
   cover property (req && op == flash_ctrl_pkg::OP_PROG ##1 status[0]);
   cover property (rdReq ##1 ack);
   cover property (status[flash_ctrl_pkg::ST_IRQ]);
endmodule

// ==== tb_top.sv ====
// Self-checking bench: software port drives the host end, the link joins the controller
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_top;
   // Clock, reset and software port
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [31:0] regRdata;
   logic debugMode = 1'b0;
   logic prefetchOn;
   logic halfCycleOn;
   logic waitState;
   logic irq;
   logic [31:0] rv;
   int bad_count = 0;
   int cmp_count = 0;
   // Host forces the wait bit at this clock rate, so every control word carries it
   localparam logic [31:0] WT = 32'h1 << flash_ctrl_pkg::CTRL_WAIT;

   flash_link_if link();
   flash_host u_flash_host (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .link(link));
   flash_ctrl u_flash_ctrl (.clock(clock), .arst_n(arst_n), .link(link),
      .debugMode(debugMode), .prefetchOn(prefetchOn), .halfCycleOn(halfCycleOn),
      .waitState(waitState), .irq(irq));
   flash_ctrl_asserts u_flash_ctrl_asserts (.clock(clock), .arst_n(arst_n), .req(link.req),
      .op(link.op), .wdata(link.wdata), .addr(link.addr), .rdReq(link.rdReq), .ack(link.ack),
      .rdata(link.rdata), .status(link.status), .ctrlState(link.ctrlState));

   // 50 MHz clock
   initial begin
      forever #10 clock = ~clock;
   end

   // Reset held 3 cycles, then room for the option reload before any request
   task automatic rst();
      arst_n <= 1'b0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      repeat (12) @(posedge clock);
   endtask
   // One-cycle write strobe; a gap cycle follows so strobes never collide
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 rv = regRdata;
   endtask
   // Command: request one cycle later, answer the cycle after
   task automatic cmd(input flash_ctrl_pkg::op_e o, input logic [9:0] a, input logic [31:0] d);
      wr(flash_ctrl_pkg::HREG_ADDR, {22'h0, a});
      wr(flash_ctrl_pkg::HREG_DATA, d);
      wr(flash_ctrl_pkg::HREG_CMD, {29'h0, o});
      repeat (3) @(posedge clock);
   endtask
   task automatic unlock(input flash_ctrl_pkg::op_e o);
      cmd(o, 10'h000, flash_ctrl_pkg::FIRST_UNLOCK_KEY);
      cmd(o, 10'h000, flash_ctrl_pkg::SECOND_UNLOCK_KEY);
   endtask
   task automatic st(input int b, input logic e, input string nm);
      rd(flash_ctrl_pkg::HREG_STATUS);
      `CHK(nm, e, rv[b])
   endtask
   // Array read: address written, fetched over the link, then read back
   task automatic rda(input logic [9:0] a, input logic [15:0] e);
      wr(flash_ctrl_pkg::HREG_READ, {22'h0, a});
      repeat (3) @(posedge clock);
      rd(flash_ctrl_pkg::HREG_READ);
      `CHK("half-word", e, rv[15:0])
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst();
      `CHK("prefetchOn", 1'b1, prefetchOn)
      st(flash_ctrl_pkg::ST_LOCKED, 1'b1, "locked");
      unlock(flash_ctrl_pkg::OP_KEY);
      st(flash_ctrl_pkg::ST_LOCKED, 1'b0, "locked");
      $display("test unlock done");
      // Option image: erase, level 0 code, page group 0 protected
      unlock(flash_ctrl_pkg::OP_OPTKEY);
      st(flash_ctrl_pkg::ST_OPT_WEN, 1'b1, "optWen");
      cmd(flash_ctrl_pkg::OP_CTRL, 10'h000, WT | (32'h1 << flash_ctrl_pkg::CTRL_OPT_ERASE));
      st(0, 1'b1, "done");
      `CHK("waitState", 1'b1, waitState)
      `CHK("halfCycleOn", 1'b0, halfCycleOn)
      cmd(flash_ctrl_pkg::OP_OPT_PROG, 10'h000, {24'h0, flash_ctrl_pkg::PROT_LEVEL0_CODE});
      cmd(flash_ctrl_pkg::OP_OPT_PROG, 10'h004, 32'hfe);
      cmd(flash_ctrl_pkg::OP_CTRL, 10'h000, WT | (32'h1 << flash_ctrl_pkg::CTRL_OPT_WEN_CLR));
      st(flash_ctrl_pkg::ST_OPT_WEN, 1'b0, "optWen");
      $display("test option done");
      // New option values only count after this reset
      rst();
      unlock(flash_ctrl_pkg::OP_KEY);
      cmd(flash_ctrl_pkg::OP_MASS_ERASE, 10'h000, 32'h0);
      rda(10'h053, 16'hffff);
      // Clear the flag left by the mass erase so the program's completion shows
      cmd(flash_ctrl_pkg::OP_CTRL, 10'h000, WT | (32'h1 << flash_ctrl_pkg::CTRL_IRQ_EN)
         | (32'h1 << flash_ctrl_pkg::CTRL_STATUS_CLR));
      st(flash_ctrl_pkg::ST_DONE, 1'b0, "done");
      cmd(flash_ctrl_pkg::OP_PROG, 10'h053, 32'h1234);
      st(0, 1'b1, "done");
      `CHK("irq", 1'b1, irq)
      rda(10'h053, 16'h1234);
      cmd(flash_ctrl_pkg::OP_PROG, 10'h053, 32'h5678);
      st(flash_ctrl_pkg::ST_PROG_ERR, 1'b1, "progErr");
      rda(10'h053, 16'h1234);
      $display("test program done");
      // Pages 0-3 protected by a zero bit, page 4 in the next group is free
      cmd(flash_ctrl_pkg::OP_PROG, 10'h030, 32'h0001);
      st(flash_ctrl_pkg::ST_WP_ERR, 1'b1, "wpErr");
      rda(10'h030, 16'hffff);
      cmd(flash_ctrl_pkg::OP_PROG, 10'h040, 32'hbeef);
      rda(10'h040, 16'hbeef);
      cmd(flash_ctrl_pkg::OP_PAGE_ERASE, 10'h050, 32'h0);
      rda(10'h053, 16'hffff);
      rda(10'h040, 16'hbeef);
      $display("test protect done");
      // Level 1 after reset: debug access sees no array, user access sees it
      unlock(flash_ctrl_pkg::OP_OPTKEY);
      cmd(flash_ctrl_pkg::OP_OPT_PROG, 10'h000, 32'h0);
      rst();
      debugMode <= 1'b1;
      rda(10'h040, 16'h0000);
      debugMode <= 1'b0;
      rda(10'h040, 16'hbeef);
      unlock(flash_ctrl_pkg::OP_KEY);
      $display("test level done");
      // Relock, refused control write, then a wrong key kills until reset
      cmd(flash_ctrl_pkg::OP_CTRL, 10'h000, WT | 32'h1);
      st(flash_ctrl_pkg::ST_LOCKED, 1'b1, "locked");
      cmd(flash_ctrl_pkg::OP_CTRL, 10'h000, 32'h0);
      cmd(flash_ctrl_pkg::OP_KEY, 10'h000, 32'h0);
      st(flash_ctrl_pkg::ST_DEAD, 1'b1, "dead");
      unlock(flash_ctrl_pkg::OP_KEY);
      st(flash_ctrl_pkg::ST_LOCKED, 1'b1, "locked");
      $display("test lock done");
      results();
   end

   // Watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      #200000;
      bad_count++;
      $display("watchdog expired");
      results();
   end
endmodule
